/* File: logic/wtc_cfg.svh */
/*
  constants for the waveform trigger controller: modes, timing, widths.
  assumes a 125 MHz sample clock on the controller.
*/
`ifndef WTC_CFG_SVH
`define WTC_CFG_SVH
`define WTC_CLK_PERIOD_PS 8000
`define WTC_FIXED_LAT_PS 35000
`define WTC_FIXED_LAT_CYC ((`WTC_FIXED_LAT_PS + `WTC_CLK_PERIOD_PS - 1) / `WTC_CLK_PERIOD_PS)
`define WTC_SYNC_LAT_CYC 5
`define WTC_RETRIG_CYC (`WTC_FIXED_LAT_CYC + `WTC_SYNC_LAT_CYC)
`define WTC_LAT_W 3
`define WTC_DLY_W 16
`define WTC_BURST_W 13
`define WTC_BURST_MAX 13'h1000
`define WTC_ADDR_W 12
`define WTC_MODE_CONT 2'h0
`define WTC_MODE_SINGLE 2'h1
`define WTC_MODE_BURST 2'h2
`define WTC_MODE_GATE 2'h3
`endif

/* File: logic/wtc_latency.sv */
/*
  fixed latency shift line for the trigger start pulse.
  assumes one clock; depth fixed by the configuration header.
*/
`timescale 1ns/10ps
`include "wtc_cfg.svh"
module wtc_latency (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pulse in and delayed out
  input wire logic pulse_in,
  output logic pulse_out
);
  logic [`WTC_FIXED_LAT_CYC-1:0] line_ff;
  genvar i;
  generate
    for (i = 0; i < `WTC_FIXED_LAT_CYC; i++) begin : g_stage
      always_ff @(posedge clk) begin
        if (!rst_n) line_ff[i] <= 1'b0;
        else if (i == 0) line_ff[i] <= pulse_in;
        else line_ff[i] <= line_ff[(i == 0) ? 0 : i-1];
      end
    end
  endgenerate
  always_ff @(posedge clk) begin
    if (!rst_n) pulse_out <= 1'b0;
    else pulse_out <= line_ff[`WTC_FIXED_LAT_CYC-1];
  end
endmodule // wtc_latency

/* File: logic/wtc_pkg.sv */
/*
  types for the waveform trigger controller.
  assumes wtc_cfg.svh supplies the numeric constants.
*/
package wtc_pkg;
  typedef enum logic [3:0] {
    WTC_IDLE = 4'h1,
    WTC_LAT  = 4'h2,
    WTC_DLY  = 4'h4,
    WTC_PLAY = 4'h8
  } wtc_state_t;
endpackage

/* File: logic/wtc_trigger_ctrl.sv */
/*
  trigger sequencer for waveform playback: four modes, three trigger
  sources, programmable delay, fixed latency.
  assumes the trigger input is an already thresholded comparator level,
  asynchronous to MCLK; manual and bus commands are MCLK pulses.
*/
`timescale 1ns/10ps
`include "wtc_cfg.svh"
// Function
// [R1] four modes: continuous, single, burst, gated
// [R2] continuous replays while channel enabled
// [R3] single: one cycle per accepted trigger
// [R4] triggers from external, manual or bus
// [R5] single: triggers during playback discarded
// [R6] burst plays programmed count, up to 4096
// [R7] burst ignores triggers until last cycle
// [R8] gated output only while gate qualified
// [R9] gated output starts on gate leading edge
// [R10] after gate trailing edge finish cycle, stop
// [R11] programmable delay added after latency
// [R12] fixed latency portion, nominally 35 ns
// [R13] synchroniser adds five to six clocks
// [R14] start uncertainty at most one clock
// [R15] triggers closer than retrigger time ignored
// [R16] slope select for external edge
// [R17] idle output and rearmed detector when stopped
module wtc_trigger_ctrl (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // configuration
  input wire logic CH_ENABLE,
  input wire logic [1:0] TRIG_MODE,
  input wire logic SLOPE_FALL,
  input wire logic [`WTC_DLY_W-1:0] TRIG_DELAY,
  input wire logic [`WTC_BURST_W-1:0] BURST_COUNT,
  input wire logic [`WTC_ADDR_W-1:0] WAVE_LAST,
  // trigger sources
  input wire logic EXT_TRIG,
  input wire logic MANUAL_TRIG,
  input wire logic BUS_TRIG,
  // playback and trigger status
  output logic PLAY_ACTIVE,
  output logic [`WTC_ADDR_W-1:0] PLAY_ADDR,
  output logic CYCLE_END,
  output logic TRIG_ACCEPTED,
  output logic TRIG_ARMED
);
  // ----------------------------------------
  // synchroniser and edge detect
  // ----------------------------------------
  logic ext_s1_ff, ext_s2_ff, ext_s3_ff;
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
    end else begin
      ext_s1_ff <= EXT_TRIG;  // [R13]
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
    end
  end
  wire ext_rise = ext_s2_ff & ~ext_s3_ff;
  wire ext_fall = ~ext_s2_ff & ext_s3_ff;
  wire ext_edge = SLOPE_FALL ? ext_fall : ext_rise;  // [R16]
  wire gate_lvl = ext_s2_ff;  // [R8]
  wire any_trig = ext_edge | MANUAL_TRIG | BUS_TRIG;  // [R4]

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  wire mode_cont = (TRIG_MODE == `WTC_MODE_CONT);  // [R1]
  wire mode_single = (TRIG_MODE == `WTC_MODE_SINGLE);
  wire mode_burst = (TRIG_MODE == `WTC_MODE_BURST);
  wire mode_gate = (TRIG_MODE == `WTC_MODE_GATE);

  // ----------------------------------------
  // retrigger holdoff
  // ----------------------------------------
  logic [`WTC_LAT_W:0] hold_ff;
  wire hold_busy = (hold_ff != '0);

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  wtc_pkg::wtc_state_t state_ff, nxt_state;
  logic [`WTC_DLY_W-1:0] dly_ff;
  logic [`WTC_BURST_W-1:0] cyc_ff;
  logic [`WTC_ADDR_W-1:0] addr_ff;
  logic stop_ff;
  wire lat_done;
  wire idle = (state_ff == wtc_pkg::WTC_IDLE);
  // armed only when stopped and past the holdoff
  wire armed = idle & ~hold_busy & CH_ENABLE;  // [R5] [R7] [R15] [R17]
  wire gate_start = mode_gate & ext_rise;  // [R9]
  wire accept = armed & ((mode_single | mode_burst) & any_trig | gate_start);
  wire cont_start = idle & mode_cont & CH_ENABLE;  // [R2]
  wire at_end = (addr_ff == WAVE_LAST);
  wire [`WTC_BURST_W-1:0] burst_n = (BURST_COUNT == '0) ? 13'h1 :
                 (BURST_COUNT > `WTC_BURST_MAX) ? `WTC_BURST_MAX : BURST_COUNT;  // [R6]
  wire last_cycle = mode_single | (mode_burst & (cyc_ff + 13'h1 >= burst_n)) |
                    (mode_gate & (stop_ff | ~gate_lvl)) | ~CH_ENABLE;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      wtc_pkg::WTC_IDLE: begin
        if (cont_start) nxt_state = wtc_pkg::WTC_PLAY;
        else if (accept) nxt_state = wtc_pkg::WTC_LAT;
      end
      wtc_pkg::WTC_LAT: begin
        if (lat_done) nxt_state = (TRIG_DELAY == '0) ? wtc_pkg::WTC_PLAY : wtc_pkg::WTC_DLY;
      end
      wtc_pkg::WTC_DLY: begin
        if (dly_ff == TRIG_DELAY - 16'h1) nxt_state = wtc_pkg::WTC_PLAY;  // [R11]
      end
      wtc_pkg::WTC_PLAY: begin
        if (at_end & ~mode_cont & last_cycle) nxt_state = wtc_pkg::WTC_IDLE;  // [R3] [R10]
        else if (at_end & mode_cont & ~CH_ENABLE) nxt_state = wtc_pkg::WTC_IDLE;
      end
      default: nxt_state = wtc_pkg::WTC_IDLE;
    endcase
  end

  // fixed latency of the accepted trigger
  wtc_latency u_lat (
    .clk(MCLK),
    .rst_n(RST_N),
    .pulse_in(accept),  // [R12] [R14]
    .pulse_out(lat_done)
  );

  wire playing = (state_ff == wtc_pkg::WTC_PLAY);
  wire [`WTC_ADDR_W-1:0] nxt_addr = (playing & ~at_end) ? addr_ff + 12'h1 : '0;
  wire [`WTC_BURST_W-1:0] nxt_cyc = ~playing ? '0 : (at_end ? cyc_ff + 13'h1 : cyc_ff);
  // a gate that drops arms the stop at the next cycle end
  wire nxt_stop = playing & (stop_ff | (mode_gate & ~gate_lvl & ~at_end));  // [R10]

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state_ff <= wtc_pkg::WTC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // delay, cycle and holdoff counters
  // ----------------------------------------
  wire [`WTC_DLY_W-1:0] nxt_dly = (state_ff == wtc_pkg::WTC_DLY) ? dly_ff + 16'h1 : '0;
  // reload on every taken trigger, count down to zero
  wire [`WTC_LAT_W:0] nxt_hold = accept ? (`WTC_LAT_W+1)'(`WTC_RETRIG_CYC) :
                                 (hold_busy ? hold_ff - 4'h1 : hold_ff);  // [R15]

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      dly_ff <= '0;
    end else begin
      dly_ff <= nxt_dly;  // [R11]
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      cyc_ff <= '0;
    end else begin
      cyc_ff <= nxt_cyc;  // [R6]
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      hold_ff <= '0;
    end else begin
      hold_ff <= nxt_hold;  // [R15]
    end
  end

  // ----------------------------------------
  // sample address and gate stop
  // ----------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      addr_ff <= '0;
    end else begin
      addr_ff <= nxt_addr;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      stop_ff <= 1'b0;
    end else begin
      stop_ff <= nxt_stop;  // [R10]
    end
  end

  // ----------------------------------------
  // registered playback outputs
  // ----------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      PLAY_ACTIVE <= 1'b0;
      PLAY_ADDR <= '0;
      CYCLE_END <= 1'b0;
    end else begin
      PLAY_ACTIVE <= playing;  // [R17]
      PLAY_ADDR <= playing ? addr_ff : '0;
      CYCLE_END <= playing & at_end;
    end
  end

  // ----------------------------------------
  // registered trigger status
  // ----------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      TRIG_ACCEPTED <= 1'b0;
      TRIG_ARMED <= 1'b0;
    end else begin
      TRIG_ACCEPTED <= accept;
      TRIG_ARMED <= armed;  // [R17]
    end
  end
endmodule // wtc_trigger_ctrl

/* File: tb/tb_top.sv */
/* self-checking bench for the trigger controller
   assumes wtc_ext_src drives the trigger pin, wtc_monitor bound */
`timescale 1ns/10ps
module tb_top;
  logic MCLK = 0, RST_N = 0, CH_ENABLE = 1, SLOPE_FALL = 0, MANUAL_TRIG = 0, BUS_TRIG = 0;
  logic lvl = 0;
  logic [1:0] TRIG_MODE = 2'h1;
  logic [15:0] TRIG_DELAY = 16'h0;
  logic [12:0] BURST_COUNT = 13'h3;
  logic [11:0] WAVE_LAST = 12'h3;
  logic PLAY_ACTIVE, CYCLE_END, TRIG_ACCEPTED, TRIG_ARMED, EXT_TRIG;
  logic [11:0] PLAY_ADDR;
  int bad_count = 0, total_checks = 0, s0, s1, n;
  always #4 MCLK = ~MCLK;
  wtc_ext_src src_u (.want_level(lvl), .ext_trig(EXT_TRIG));
  wtc_trigger_ctrl dut_u (.*);
  // ----------
  // helpers
  // ----------
  task automatic tick();
    @(posedge MCLK);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // fire one trigger, retrigger mid play, count clocks with PLAY_ACTIVE high
  task automatic go(input logic [2:0] src, output int st);
    int t;
    for (t = 0; t < 60 && TRIG_ARMED !== 1'b1; t++) tick();
    chk("armed", 1, TRIG_ARMED);
    if (t == 60) give_verdict();
    MANUAL_TRIG = src[0];
    BUS_TRIG = src[1];
    lvl = src[2] ? ~lvl : lvl;
    n = 0;
    st = 0;
    for (t = 0; t < 20000 && !(n > 0 && PLAY_ACTIVE !== 1'b1); t++) begin
      tick();
      MANUAL_TRIG = (n == 2);
      BUS_TRIG = 1'b0;
      if (n == 3 && TRIG_MODE == 2'h3) lvl = 1'b0;
      if (PLAY_ACTIVE === 1'b1 && n == 0) st = t + 1;
      n += (PLAY_ACTIVE === 1'b1);
    end
    if (t == 20000) begin
      chk("timeout", 0, 1);
      give_verdict();
    end
  endtask
  // ----------
  // scenarios
  // ----------
  task automatic t_single();
    go(3'h1, s0); chk("single", 4, n);
    go(3'h2, s1); chk("bus", 4, n);
    chk("lat", 1, s0 > 6 && s0 < 9);
    TRIG_DELAY = 16'h5;
    go(3'h1, s1); chk("delay", 5, s1 - s0);
    TRIG_DELAY = 16'h0;
    $display("test single done");
  endtask
  task automatic t_burst();
    TRIG_MODE = 2'h2;
    go(3'h2, s1); chk("burst", 12, n);
    BURST_COUNT = 13'h0;
    go(3'h1, s1); chk("burst0", 4, n);
    WAVE_LAST = 12'h0;
    BURST_COUNT = 13'h1fff;
    go(3'h1, s1); chk("burstmax", 16'h1000, n);
    WAVE_LAST = 12'h3;
    $display("test burst done");
  endtask
  task automatic t_ext();
    TRIG_MODE = 2'h1;
    go(3'h4, s1); chk("rise", 4, n);
    SLOPE_FALL = 1'b1;
    go(3'h4, s1); chk("fall", 4, n);
    TRIG_MODE = 2'h3;
    SLOPE_FALL = 1'b0;
    go(3'h4, s1); chk("gate", 8, n);
    $display("test ext done");
  endtask
  task automatic t_cont();
    TRIG_MODE = 2'h0;
    repeat (40) tick();
    chk("run", 1, PLAY_ACTIVE);
    CH_ENABLE = 1'b0;
    repeat (8) tick();
    chk("stop", 0, PLAY_ACTIVE);
    $display("test cont done");
  endtask
  initial begin
    repeat (12) tick();
    RST_N = 1'b1;
    t_single();
    t_burst();
    t_ext();
    t_cont();
    give_verdict();
  end
endmodule // tb_top

/* File: tb/wtc_ext_src.sv */
/* external trigger source model: drives the thresholded trigger level
   off the clock edge; assumes the bench asks for the level it wants */
`timescale 1ns/10ps
module wtc_ext_src (
  // request and pin
  input wire logic want_level,
  output wire logic ext_trig
);
  // held as long as asked, skewed off the edge
  assign #3 ext_trig = want_level;
endmodule // wtc_ext_src

/* File: tb/wtc_monitor.sv */
/* checker on the trigger controller ports
   assumes one clock, reset synchronous and active low */
`timescale 1ns/10ps
module wtc_monitor (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // watched
  input wire logic [1:0] TRIG_MODE,
  input wire logic [15:0] TRIG_DELAY,
  input wire logic [11:0] WAVE_LAST,
  input wire logic TRIG_ACCEPTED,
  input wire logic PLAY_ACTIVE,
  input wire logic [11:0] PLAY_ADDR,
  input wire logic CYCLE_END
);
  // ----------
  // checks
  // ----------
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  lat_min_a: assert property (TRIG_ACCEPTED |-> !PLAY_ACTIVE[*5]) else $error("early");
  acc_gap_a: assert property (TRIG_ACCEPTED |=> !TRIG_ACCEPTED[*8]) else $error("regrab");
  acc_mode_a: assert property (TRIG_ACCEPTED |-> $past(TRIG_MODE) != 2'h0) else $error("mode");
  start_time_a: assert property (TRIG_ACCEPTED && TRIG_DELAY == 16'h0 |-> ##[5:7] PLAY_ACTIVE)
    else $error("late");
  idle_addr_a: assert property (!PLAY_ACTIVE |-> PLAY_ADDR == 12'h0) else $error("idle");
  cycle_end_a: assert property (CYCLE_END |-> PLAY_ACTIVE && PLAY_ADDR == WAVE_LAST)
    else $error("end");
  addr_step_a: assert property (PLAY_ACTIVE && !CYCLE_END |=> PLAY_ACTIVE
    && PLAY_ADDR == $past(PLAY_ADDR) + 12'h1) else $error("step");
  whole_cycle_a: assert property ($fell(PLAY_ACTIVE) |-> $past(CYCLE_END)) else $error("cut");
  cover property (TRIG_ACCEPTED);
  cover property (CYCLE_END && TRIG_MODE == 2'h2);
  cover property ($fell(PLAY_ACTIVE));
endmodule // wtc_monitor
bind wtc_trigger_ctrl wtc_monitor mon_u (.*);
